//--- fcc_pkg.sv
// Package of constants and types for the flash command control block
package fcc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] ADDR_TARGET_OFFSET = 12'h000;
  localparam logic [11:0] ADDR_PROGRAM_WORD  = 12'h004;
  localparam logic [11:0] ADDR_COMMAND       = 12'h008;
  localparam logic [15:0] UNLOCK_KEY         = 16'hA442;
  localparam int          OFFSET_W           = 15;
  localparam int          BIT_WRITE          = 0;
  localparam int          BIT_ERASE          = 1;
  localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int ERASE_TIME_MS  = 25;
  localparam int PROG_TIME_US   = 50;
  // Longest times round down
  localparam int ERASE_CYCLES   = CLK_HZ / 1000 * ERASE_TIME_MS;
  localparam int PROG_CYCLES    = CLK_HZ / 1_000_000 * PROG_TIME_US;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    FCC_IDLE  = 2'b00,
    FCC_ERASE = 2'b01,
    FCC_PROG  = 2'b10
  } fcc_op_t;
endpackage

//--- fcc_op_if.sv
// Interface carrying one flash operation request and its busy state
`timescale 1ns/10ps
interface fcc_op_if;
  logic                        start;
  fcc_pkg::fcc_op_t            op;
  logic [fcc_pkg::OFFSET_W-1:0] offset;
  logic [31:0]                 data;
  logic                        erase_busy;
  logic                        prog_busy;
  modport ctrl (output start, output op, output offset, output data,
                input erase_busy, input prog_busy);
  modport seq  (input start, input op, input offset, input data,
                output erase_busy, output prog_busy);
endinterface

//--- fcc_sequencer.sv
// Flash operation sequencer driving the array and timing each operation
`timescale 1ns/10ps
module fcc_sequencer #(
  parameter int ERASE_CYC = fcc_pkg::ERASE_CYCLES,
  parameter int PROG_CYC  = fcc_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Request
  fcc_op_if.seq            rq,
  // Array side
  output logic             arr_erase,
  output logic             arr_prog,
  output logic [14:0]      arr_offset,
  output logic [31:0]      arr_data,
  input  wire logic        arr_done
);
  // ************************************************************
  // State
  // ************************************************************
  fcc_pkg::fcc_op_t st_r, st_nxt;
  logic [19:0]      cnt_r, cnt_nxt;
  logic             er_r, er_nxt, pg_r, pg_nxt;
  logic [14:0]      off_r, off_nxt;
  logic [31:0]      dat_r, dat_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    er_nxt  = 1'b0;
    pg_nxt  = 1'b0;
    off_nxt = off_r;
    dat_nxt = dat_r;
    case (st_r)
      fcc_pkg::FCC_IDLE: begin
        if (rq.start) begin
          st_nxt  = rq.op;
          off_nxt = rq.offset;
          dat_nxt = rq.data;
          er_nxt  = (rq.op == fcc_pkg::FCC_ERASE);
          pg_nxt  = (rq.op == fcc_pkg::FCC_PROG);
          cnt_nxt = (rq.op == fcc_pkg::FCC_ERASE) ? 20'(ERASE_CYC - 1)
                                                  : 20'(PROG_CYC - 1);
        end
      end
      fcc_pkg::FCC_ERASE, fcc_pkg::FCC_PROG: begin
        // Ends on array done or at the longest documented time
        if (arr_done || cnt_r == 20'h0_0000) begin
          st_nxt = fcc_pkg::FCC_IDLE;
        end else begin
          cnt_nxt = cnt_r - 20'h0_0001;
        end
      end
      default: begin
        st_nxt = fcc_pkg::FCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= fcc_pkg::FCC_IDLE;
      cnt_r <= 20'h0_0000;
      er_r  <= 1'b0;
      pg_r  <= 1'b0;
      off_r <= 15'h0000;
      dat_r <= 32'h0000_0000;
    end else if (ce) begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      er_r  <= er_nxt;
      pg_r  <= pg_nxt;
      off_r <= off_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign arr_erase     = er_r;
  assign arr_prog      = pg_r;
  assign arr_offset    = off_r;
  assign arr_data      = dat_r;
  assign rq.erase_busy = (st_r == fcc_pkg::FCC_ERASE);
  assign rq.prog_busy  = (st_r == fcc_pkg::FCC_PROG);
endmodule

//--- fcc_axil_slave.sv
// AXI4-Lite write and read channel handshake for the register file
`timescale 1ns/10ps
module fcc_axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Write channels
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  // Register file side
  output logic             wr_en,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic             rd_en,
  output logic [11:0]      rd_addr
);
  // ************************************************************
  // Capture of address and data
  // ************************************************************
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;

  always_comb begin
    aw_nxt  = aw_r;
    w_nxt   = w_r;
    b_nxt   = b_r;
    r_nxt   = r_r;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    if (awvalid && awready) begin
      aw_nxt  = 1'b1;
      awa_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_nxt  = 1'b1;
      wd_nxt = wdata;
      ws_nxt = wstrb;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      b_nxt  = 1'b1;
    end
    if (b_r && bready) begin
      b_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      r_nxt = 1'b1;
    end else if (r_r && rready) begin
      r_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r  <= 1'b0;
      w_r   <= 1'b0;
      b_r   <= 1'b0;
      r_r   <= 1'b0;
      awa_r <= 12'h000;
      wd_r  <= 32'h0000_0000;
      ws_r  <= 4'h0;
    end else if (ce) begin
      aw_r  <= aw_nxt;
      w_r   <= w_nxt;
      b_r   <= b_nxt;
      r_r   <= r_nxt;
      awa_r <= awa_nxt;
      wd_r  <= wd_nxt;
      ws_r  <= ws_nxt;
    end
  end

  assign awready = ce && !aw_r && !b_r;
  assign wready  = ce && !w_r && !b_r;
  assign bvalid  = b_r;
  assign arready = ce && !r_r;
  assign rvalid  = r_r;
  assign wr_en   = ce && aw_r && w_r;
  assign wr_addr = awa_r;
  assign wr_data = wd_r;
  assign wr_strb = ws_r;
  assign rd_en   = arvalid && arready;
  assign rd_addr = araddr;
endmodule

//--- fcc_top.sv
// Flash command control: keyed command register, address, data and sequencer
// Functional notes
// - Erase bit erases page at target offset
// - Writing zero changes nothing, never cancels
// - Erase bit reads one while erasing
// - Erase busy for at most 25 ms
// - Program bit writes data word at offset
// - Program bit reads one while programming
// - Program busy for at most 50 us
// - Command write starts cycle at held offset
// - Offset is 15 bits, upper bits zero
`timescale 1ns/10ps
module fcc_top #(
  parameter int ERASE_CYC = fcc_pkg::ERASE_CYCLES,
  parameter int PROG_CYC  = fcc_pkg::PROG_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Flash array
  output logic             arr_erase,
  output logic             arr_prog,
  output logic [14:0]      arr_offset,
  output logic [31:0]      arr_data,
  input  wire logic        arr_done
);
  // ************************************************************
  // Bus slave
  // ************************************************************
  logic        wr_en, rd_en;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  fcc_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .araddr  (s_axi_araddr),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .rd_en   (rd_en),
    .rd_addr (rd_addr)
  );

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == fcc_pkg::ADDR_TARGET_OFFSET) || (a == fcc_pkg::ADDR_PROGRAM_WORD) ||
                (a == fcc_pkg::ADDR_COMMAND);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  fcc_op_if rq ();

  logic [14:0] flash_target_offset_r, flash_target_offset_nxt;
  logic [31:0] flash_program_word_r, flash_program_word_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        start_r, start_nxt;
  fcc_pkg::fcc_op_t op_r, op_nxt;
  logic [31:0] merged, ofs_merged;
  logic        key_ok, busy_any;

  assign busy_any = rq.erase_busy || rq.prog_busy || start_r;

  always_comb begin
    flash_target_offset_nxt = flash_target_offset_r;
    flash_program_word_nxt  = flash_program_word_r;
    bresp_nxt = bresp_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    start_nxt = 1'b0;
    op_nxt    = op_r;
    merged    = merge(fcc_pkg::RESET_WORD, wr_data, wr_strb);
    ofs_merged = merge({17'h0_0000, flash_target_offset_r}, wr_data, wr_strb);
    key_ok    = (merged[31:16] == fcc_pkg::UNLOCK_KEY);
    if (wr_en) begin
      bresp_nxt = is_mapped(wr_addr) ? fcc_pkg::RESP_OKAY : fcc_pkg::RESP_SLVERR;
      case (wr_addr)
        fcc_pkg::ADDR_TARGET_OFFSET: begin
          flash_target_offset_nxt = ofs_merged[14:0];
        end
        fcc_pkg::ADDR_PROGRAM_WORD: begin
          flash_program_word_nxt = merge(flash_program_word_r, wr_data, wr_strb);
        end
        fcc_pkg::ADDR_COMMAND: begin
          // Zero bits, bad key or busy block leave everything unchanged
          if (key_ok && !busy_any) begin
            if (merged[fcc_pkg::BIT_ERASE]) begin
              start_nxt = 1'b1;
              op_nxt    = fcc_pkg::FCC_ERASE;
            end else if (merged[fcc_pkg::BIT_WRITE]) begin
              start_nxt = 1'b1;
              op_nxt    = fcc_pkg::FCC_PROG;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      rresp_nxt = is_mapped(rd_addr) ? fcc_pkg::RESP_OKAY : fcc_pkg::RESP_SLVERR;
      case (rd_addr)
        fcc_pkg::ADDR_TARGET_OFFSET: rdata_nxt = {17'h0_0000, flash_target_offset_r};
        fcc_pkg::ADDR_PROGRAM_WORD:  rdata_nxt = flash_program_word_r;
        fcc_pkg::ADDR_COMMAND: begin
          // Key field reads zero; bits show busy
          rdata_nxt = {30'h0000_0000,
                       rq.erase_busy || (start_r && op_r == fcc_pkg::FCC_ERASE),
                       rq.prog_busy  || (start_r && op_r == fcc_pkg::FCC_PROG)};
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_target_offset_r <= 15'h0000;
      flash_program_word_r  <= 32'h0000_0000;
      bresp_r <= fcc_pkg::RESP_OKAY;
      rresp_r <= fcc_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      start_r <= 1'b0;
      op_r    <= fcc_pkg::FCC_IDLE;
    end else if (ce) begin
      flash_target_offset_r <= flash_target_offset_nxt;
      flash_program_word_r  <= flash_program_word_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      start_r <= start_nxt;
      op_r    <= op_nxt;
    end
  end

  assign s_axi_bresp = bresp_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ************************************************************
  // Sequencer
  // ************************************************************
  assign rq.start  = start_r;
  assign rq.op     = op_r;
  assign rq.offset = flash_target_offset_r;
  assign rq.data   = flash_program_word_r;

  fcc_sequencer #(
    .ERASE_CYC (ERASE_CYC),
    .PROG_CYC  (PROG_CYC)
  ) u_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .rq         (rq),
    .arr_erase  (arr_erase),
    .arr_prog   (arr_prog),
    .arr_offset (arr_offset),
    .arr_data   (arr_data),
    .arr_done   (arr_done)
  );
endmodule

//--- fcc_monitor.sv
// Checker for the flash command control ports
`timescale 1ns/10ps
module fcc_monitor #(
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC  = 10
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Array
  input wire logic        arr_erase,
  input wire logic        arr_prog,
  input wire logic [14:0] arr_offset,
  input wire logic        arr_done
);
  // ************************************************************
  // Helpers
  // ************************************************************
  logic [31:0] age;
  logic [7:0]  w_age;
  logic        pend, er, ar_cmd, ar_off, ar_bsy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age    <= '0;
      w_age  <= '0;
      pend   <= 1'b0;
      er     <= 1'b0;
      ar_cmd <= 1'b0;
      ar_off <= 1'b0;
      ar_bsy <= 1'b0;
    end else begin
      w_age <= (s_axi_wvalid && s_axi_wready) ? 8'h00 : w_age + {7'h00, w_age != 8'hFF};
      if (arr_erase || arr_prog) begin
        age  <= '0;
        pend <= 1'b1;
        er   <= arr_erase;
      end else begin
        age <= age + {31'h0, age != '1};
        if (arr_done || age + 4 >= (er ? ERASE_CYC : PROG_CYC)) pend <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_cmd <= s_axi_araddr == fcc_pkg::ADDR_COMMAND;
        ar_off <= s_axi_araddr == fcc_pkg::ADDR_TARGET_OFFSET;
        ar_bsy <= pend && age >= 1;
      end
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_start_cause: assert property ((arr_erase || arr_prog) |-> w_age <= 4)
    else $error("operation started without a command write");
  chk_single_op: assert property (!(arr_erase && arr_prog))
    else $error("erase and program started together");
  chk_key_zero: assert property (s_axi_rvalid && ar_cmd |-> s_axi_rdata[31:2] == 30'h0)
    else $error("command upper bits read nonzero");
  chk_offset_rd: assert property (s_axi_rvalid && ar_off |-> s_axi_rdata[31:15] == 17'h0)
    else $error("offset upper bits read nonzero");
  chk_erase_time: assert property (s_axi_rvalid && ar_cmd && s_axi_rdata[1] |-> age <= ERASE_CYC + 4)
    else $error("erase busy too long");
  chk_prog_time: assert property (s_axi_rvalid && ar_cmd && s_axi_rdata[0] |-> age <= PROG_CYC + 4)
    else $error("program busy too long");
  chk_erase_rd1: assert property ($rose(s_axi_rvalid) && ar_cmd && ar_bsy && pend && er |-> s_axi_rdata[1])
    else $error("erase bit not busy");
  chk_prog_rd1: assert property ($rose(s_axi_rvalid) && ar_cmd && ar_bsy && pend && !er |-> s_axi_rdata[0])
    else $error("program bit not busy");
  chk_offset_hold: assert property (pend && !(arr_erase || arr_prog) |-> $stable(arr_offset))
    else $error("offset moved during operation");
  cov_erase: cover property (arr_erase);
  cov_prog: cover property (arr_prog);
  cov_busy_rd: cover property ($rose(s_axi_rvalid) && ar_cmd && ar_bsy);
endmodule
bind fcc_top fcc_monitor #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_mon (.*);

//--- fcc_flash_model.sv
// Behavioural flash array answering each started operation
`timescale 1ns/10ps
module fcc_flash_model #(
  parameter int DLY = 6
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Operation
  input wire logic        arr_erase,
  input wire logic        arr_prog,
  input wire logic [14:0] arr_offset,
  input wire logic [31:0] arr_data,
  input wire logic        stall,
  output logic            arr_done
);
  int          cnt, n_ops;
  logic        busy;
  logic [1:0]  last_op;
  logic [14:0] last_off;
  logic [31:0] last_data;
  always_ff @(posedge aclk) begin
    arr_done <= 1'b0;
    if (!aresetn) begin
      busy    <= 1'b0;
      n_ops   <= 0;
      last_op <= 2'b00;
    end else if (arr_erase || arr_prog) begin
      busy      <= 1'b1;
      cnt       <= 0;
      n_ops     <= n_ops + 1;
      last_op   <= {arr_prog, arr_erase};
      last_off  <= arr_offset;
      last_data <= arr_data;
    end else if (busy && !stall) begin
      cnt <= cnt + 1;
      if (cnt == DLY) begin
        busy     <= 1'b0;
        arr_done <= 1'b1;
      end
    end
  end
endmodule

//--- testbench.sv
// Testbench for the flash command control block
`timescale 1ns/10ps
module testbench;
  localparam int EC = 200;
  localparam int PC = 40;
  localparam logic [11:0] OFS = fcc_pkg::ADDR_TARGET_OFFSET;
  localparam logic [11:0] WRD = fcc_pkg::ADDR_PROGRAM_WORD;
  localparam logic [11:0] CMD = fcc_pkg::ADDR_COMMAND;
  localparam logic [15:0] KEY = fcc_pkg::UNLOCK_KEY;
  logic        aclk, aresetn, ce, stall, arr_done, arr_erase, arr_prog;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, arr_data, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [14:0] arr_offset;
  int          error_cnt, check_count, cyc, t0, el;
  fcc_top #(.ERASE_CYC(EC), .PROG_CYC(PC)) uut (.*);
  fcc_flash_model u_arr (.*);
  // ************************************************************
  // Tasks
  // ************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) error_cnt++;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) error_cnt++;
    @(posedge aclk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rdr(CMD);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 100);
    if (n >= 100) error_cnt++;
    el = cyc - t0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************************************************
  // Clock, reset, watchdog
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    #400_000;
    error_cnt++;
    stop_test;
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {aresetn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    ce = 1'b1;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rdr(12'(i * 4));
      chk("reset value", 32'h0000_0000, rd);
    end
    rdr(12'h00C);
    chk("unmapped resp", {30'h0, fcc_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(12'h00C, 32'h1234_5678);
    chk("unmapped wr resp", {30'h0, fcc_pkg::RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
    wr(OFS, 32'hFFFF_FFFF);
    chk("offset wr resp", {30'h0, fcc_pkg::RESP_OKAY}, {30'h0, rs});
    rdr(OFS);
    chk("offset", 32'h0000_7FFF, rd);
    wr(CMD, 32'h0000_0002);
    chk("keyless resp", {30'h0, fcc_pkg::RESP_OKAY}, {30'h0, rs});
    wr(CMD, {KEY, 16'h0002}, 4'h3);
    wr(CMD, {KEY + 16'h0001, 16'h0001});
    rdr(CMD);
    chk("keyless cmd", 32'h0000_0000, rd);
    chk("keyless ops", 32'h0000_0000, u_arr.n_ops);
    $display("test key done");
    stall <= 1'b1;
    wr(OFS, 32'h0000_1234);
    wr(CMD, {KEY, 16'h0002});
    t0 = cyc;
    rdr(CMD);
    chk("erase busy", 32'h0000_0002, rd);
    wr(CMD, {KEY, 16'h0000});
    wr(CMD, {KEY, 16'h0001});
    rdr(CMD);
    chk("no cancel", 32'h0000_0002, rd);
    stall <= 1'b0;
    wait_idle();
    chk("erase end", 32'h0000_0001, {31'h0, el < EC});
    chk("erase op", 32'h0000_0001, {30'h0, u_arr.last_op});
    chk("erase ofs", 32'h0000_1234, {17'h0, u_arr.last_off});
    chk("one op", 32'h0000_0001, u_arr.n_ops);
    $display("test erase done");
    stall <= 1'b1;
    wr(WRD, 32'hCAFE_F00D);
    wr(CMD, {KEY, 16'h0001});
    t0 = cyc;
    rdr(CMD);
    chk("prog busy", 32'h0000_0001, rd);
    wait_idle();
    chk("prog time", 32'h0000_0001, {31'h0, el <= PC + 12});
    chk("prog op", 32'h0000_0002, {30'h0, u_arr.last_op});
    chk("prog data", 32'hCAFE_F00D, u_arr.last_data);
    chk("prog ofs", 32'h0000_1234, {17'h0, u_arr.last_off});
    $display("test program done");
    stop_test;
  end
endmodule
